// ### shared/mra_pkg.sv
/*
 * Constants and types shared by both ends of the mode-register link.
 * Assumes one 100 MHz clock on both ends. Both command/address halves
 * are presented in one clock cycle.
 */
// Notes on behaviour
// RL1: MODE_REG_READ_CMD waits write-to-read gap after burst write
// RL2: Only NOPs during read command period
// RL3: Temperature status refreshed every sensor interval
// RL4: Fresh temperature status on low-power exit
// RL5: Three-bit temperature code; 011b over 85C
// RL6: Host polls temperature often enough for margin
// RL7: Address 32 pattern 1010, 40 pattern 0011
// RL8: Pattern valid on bit 0 every beat
// RL9: x16: all bits copy bit 0
// RL10: x32: all bits copy bit 0
// RL11: Calibration reads only with no bank active
// RL12: Read burst is four beats, uninterrupted
// RL13: Write decoded: select low, CA3..CA0 low
// RL14: Address and data taken from CA halves
// RL15: Only NOPs during write command period
// RL16: Writes to read-only registers ignored
// RL17: Writes only when all banks idle
// RL18: Reads allowed with banks active; writes not
// RL19: Write to address 63 starts reset
// RL20: Reset returns registers to defaults
// RL21: Only NOPs during initialisation period
// RL22: Read decoded: select low, CA2..0 low, CA3 high
// RL23: Ordinary read: byte on lanes 7:0, beat 0
// RL24: Read value captured at command time
package mra_pkg;

    localparam int CA_W = 10;
    localparam int MA_W = 8;
    localparam int MD_W = 8;
    localparam int NUM_REGS = 64;
    localparam int REG_IDX_W = 6;

    localparam logic [3:0] CMD_WRITE_CODE = 4'h0;
    localparam logic [3:0] CMD_READ_CODE = 4'h8;

    localparam logic [MA_W-1:0] DEVICE_INFO_ADDR = 8'h00;
    localparam logic [MA_W-1:0] TEMP_STATUS_ADDR = 8'h04;
    localparam logic [MA_W-1:0] CAL_A_ADDR = 8'h20;
    localparam logic [MA_W-1:0] CAL_B_ADDR = 8'h28;
    localparam logic [MA_W-1:0] RESET_REG_ADDR = 8'h3F;

    // Bit n is the value of beat n
    localparam logic [3:0] CAL_A_PATTERN = 4'h5;
    localparam logic [3:0] CAL_B_PATTERN = 4'hC;

    localparam logic [MD_W-1:0] REG_RESET_VALUE = 8'h00;
    localparam logic [2:0] TEMP_RESET_CODE = 3'h0;
    localparam logic [2:0] TEMP_HOT_CODE = 3'h3;

    localparam int BURST_BEATS = 4;
    localparam int READ_LATENCY = 3;
    localparam int WRITE_LATENCY = 1;
    localparam int READ_CMD_PERIOD = 2;
    localparam int WRITE_CMD_PERIOD = 5;

    localparam int CLK_PERIOD_NS = 10;
    localparam int WTR_NS = 10;
    localparam int WTR_CYCLES = (WTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_TO_READ_GAP =
        WRITE_LATENCY + 1 + BURST_BEATS / 2 + WTR_CYCLES;

    localparam int SENSOR_INTERVAL_MS = 32;
    localparam int SENSOR_INTERVAL_CYCLES =
        SENSOR_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
    localparam int INIT_PERIOD_US = 1;
    localparam int INIT_CYCLES = INIT_PERIOD_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DEV_IDLE, DEV_RD_WAIT, DEV_RD_BURST, DEV_INIT
    } dev_state_type;

    typedef enum logic [1:0] {
        CTL_IDLE, CTL_GAP, CTL_READ, CTL_INIT
    } ctl_state_type;

endpackage

// ### shared/mra_link_if.sv
/*
 * Command/address and data link between memory controller and device.
 * Assumes the bench supplies the clock and resolves the data wire.
 */
`timescale 1ns/1ps
interface mra_link_if #(parameter int DQ_W = 16) (
    input wire logic clk
);
    import mra_pkg::*;

    logic cs_n;
    logic [CA_W-1:0] ca_rise;
    logic [CA_W-1:0] ca_fall;
    logic [DQ_W-1:0] dq;
    logic dq_oe;

    modport device (
        input clk, cs_n, ca_rise, ca_fall,
        output dq, dq_oe
    );

    modport controller (
        input clk, dq, dq_oe,
        output cs_n, ca_rise, ca_fall
    );
endinterface

// ### verilog/mra_device.sv
/*
 * Device end: decodes mode-register reads and writes, returns register
 * contents or calibration patterns, keeps temperature status, and runs
 * the reset write. Assumes the controller keeps its command spacing.
 */
`timescale 1ns/1ps
module mra_device
    import mra_pkg::*;
#(
    parameter int DQ_W = 16,
    parameter int SENSOR_CYCLES = SENSOR_INTERVAL_CYCLES,
    parameter int INIT_WAIT = INIT_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    mra_link_if.device link,
    input wire logic i_bank_active,
    input wire logic [2:0] i_temp_code,
    input wire logic i_lp_exit,
    output logic o_initialising,
    output logic [2:0] o_temp_status,
    output logic o_temp_over_85
);

    dev_state_type state_q;
    logic [MD_W-1:0] regs_q [NUM_REGS];
    logic [2:0] temp_q;
    logic [31:0] tsi_cnt_q;
    logic [31:0] init_cnt_q;
    logic [1:0] lat_cnt_q;
    logic [1:0] beat_q;
    logic cal_q;
    logic [3:0] pat_q;
    logic [MD_W-1:0] rd_byte_q;
    logic [DQ_W-1:0] dq_q;
    logic oe_q;

    logic cmd_sel;
    logic is_write;
    logic is_read;
    logic [MA_W-1:0] addr;
    logic [MD_W-1:0] wdata;
    logic read_only;
    logic [MD_W-1:0] rd_value;
    logic [DQ_W-1:0] beat_word;
    logic [1:0] next_beat;

    assign cmd_sel = !link.cs_n && (state_q == DEV_IDLE);
    assign is_write = cmd_sel
        && (link.ca_rise[3:0] == CMD_WRITE_CODE); // RL13
    assign is_read = cmd_sel
        && (link.ca_rise[3:0] == CMD_READ_CODE); // RL22
    assign addr = {link.ca_fall[1:0], link.ca_rise[9:4]}; // RL14
    assign wdata = link.ca_fall[9:2]; // RL14

    // Status, calibration and info registers cannot be written
    assign read_only = (addr == DEVICE_INFO_ADDR)
        || (addr == TEMP_STATUS_ADDR)
        || (addr == CAL_A_ADDR)
        || (addr == CAL_B_ADDR);

    always_comb begin
        if (addr == TEMP_STATUS_ADDR) begin
            rd_value = {5'h00, temp_q}; // RL5
        end else if (addr < MA_W'(NUM_REGS)) begin
            rd_value = regs_q[addr[REG_IDX_W-1:0]];
        end else begin
            rd_value = REG_RESET_VALUE;
        end
    end

    // Data for the beat that goes out next
    assign next_beat = (state_q == DEV_RD_BURST) ? beat_q + 2'd1 : 2'd0;

    genvar b;
    generate
        for (b = 0; b < DQ_W; b++) begin : g_lane
            always_comb begin
                if (cal_q) begin
                    beat_word[b] = pat_q[next_beat]; // RL8 RL9 RL10
                end else if (b < MD_W && next_beat == 2'd0) begin
                    beat_word[b] = rd_byte_q[b % MD_W]; // RL23
                end else begin
                    beat_word[b] = 1'b0;
                end
            end
        end
    endgenerate

    // Command sequencing
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q <= DEV_IDLE;
            lat_cnt_q <= 2'd0;
            beat_q <= 2'd0;
            init_cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                DEV_IDLE: begin
                    if (is_read) begin
                        state_q <= DEV_RD_WAIT;
                        lat_cnt_q <= 2'(READ_LATENCY - 1);
                    end else if (is_write && !i_bank_active // RL18
                            && addr == RESET_REG_ADDR) begin
                        state_q <= DEV_INIT; // RL19
                        init_cnt_q <= 32'(INIT_WAIT - 1);
                    end
                end
                DEV_RD_WAIT: begin
                    if (lat_cnt_q == 2'd0) begin
                        state_q <= DEV_RD_BURST;
                        beat_q <= 2'd0;
                    end else begin
                        lat_cnt_q <= lat_cnt_q - 2'd1;
                    end
                end
                DEV_RD_BURST: begin
                    // Commands ignored until burst ends
                    beat_q <= beat_q + 2'd1; // RL12
                    if (beat_q == 2'(BURST_BEATS - 1)) begin
                        state_q <= DEV_IDLE;
                    end
                end
                DEV_INIT: begin
                    if (init_cnt_q == 32'h0000_0000) begin
                        state_q <= DEV_IDLE;
                    end else begin
                        init_cnt_q <= init_cnt_q - 32'h0000_0001;
                    end
                end
                default: begin
                    state_q <= DEV_IDLE;
                end
            endcase
        end
    end

    // Read capture at command time
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cal_q <= 1'b0;
            pat_q <= 4'h0;
            rd_byte_q <= REG_RESET_VALUE;
        end else if (is_read) begin
            rd_byte_q <= rd_value; // RL24
            cal_q <= (addr == CAL_A_ADDR) || (addr == CAL_B_ADDR);
            pat_q <= (addr == CAL_A_ADDR) ? CAL_A_PATTERN
                : CAL_B_PATTERN; // RL7
        end
    end

    // Data drive
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dq_q <= '0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= (state_q == DEV_RD_WAIT && lat_cnt_q == 2'd0)
                || (state_q == DEV_RD_BURST
                && beat_q != 2'(BURST_BEATS - 1));
            if ((state_q == DEV_RD_WAIT && lat_cnt_q == 2'd0)
                    || state_q == DEV_RD_BURST) begin
                dq_q <= beat_word;
            end else begin
                dq_q <= '0;
            end
        end
    end

    // Mode register file
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= REG_RESET_VALUE;
            end
        end else if (is_write && !i_bank_active) begin // RL18
            if (addr == RESET_REG_ADDR) begin
                for (int i = 0; i < NUM_REGS; i++) begin
                    regs_q[i] <= REG_RESET_VALUE; // RL20
                end
            end else if (!read_only // RL16
                    && addr < MA_W'(NUM_REGS)) begin
                regs_q[addr[REG_IDX_W-1:0]] <= wdata;
            end
        end
    end

    // Temperature sampling
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            temp_q <= TEMP_RESET_CODE;
            tsi_cnt_q <= 32'h0000_0000;
        end else if (i_lp_exit || tsi_cnt_q == 32'h0000_0000) begin
            temp_q <= i_temp_code; // RL3 RL4
            tsi_cnt_q <= 32'(SENSOR_CYCLES - 1);
        end else begin
            tsi_cnt_q <= tsi_cnt_q - 32'h0000_0001; // RL3
        end
    end

    assign link.dq = dq_q;
    assign link.dq_oe = oe_q;
    assign o_initialising = (state_q == DEV_INIT);
    assign o_temp_status = temp_q;
    assign o_temp_over_85 = (temp_q == TEMP_HOT_CODE); // RL5

endmodule

// ### verilog/mra_controller.sv
/*
 * Controller end: issues mode-register reads and writes on the link,
 * keeps the command spacing, and collects read bursts.
 * Assumes user requests are synchronous to i_core_clk.
 */
`timescale 1ns/1ps
module mra_controller
    import mra_pkg::*;
#(
    parameter int DQ_W = 16,
    parameter int INIT_WAIT = INIT_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    mra_link_if.controller link,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [MA_W-1:0] i_req_addr,
    input wire logic [MD_W-1:0] i_req_wdata,
    input wire logic i_bank_active,
    input wire logic i_burst_write,
    output logic o_req_ready,
    output logic o_req_refused,
    output logic o_rd_valid,
    output logic [MD_W-1:0] o_rd_data,
    output logic [3:0] o_rd_pattern,
    output logic o_busy
);

    ctl_state_type state_q;
    logic cs_n_q;
    logic [CA_W-1:0] ca_rise_q;
    logic [CA_W-1:0] ca_fall_q;
    logic [31:0] gap_q;
    logic [3:0] wtr_q;
    logic [1:0] beat_q;
    logic [MD_W-1:0] rd_data_q;
    logic [3:0] pat_q;
    logic rd_valid_q;
    logic refused_q;
    logic take;
    logic illegal;
    logic is_cal;

    assign o_req_ready = (state_q == CTL_IDLE)
        && (i_req_write || wtr_q == 4'h0); // RL1
    assign take = i_req_valid && o_req_ready;
    assign is_cal = (i_req_addr == CAL_A_ADDR)
        || (i_req_addr == CAL_B_ADDR);
    assign illegal = i_bank_active
        && (i_req_write || is_cal); // RL11 RL17 RL18

    // Write-to-read spacing
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wtr_q <= 4'h0;
        end else if (i_burst_write) begin
            wtr_q <= 4'(WR_TO_READ_GAP - 1); // RL1
        end else if (wtr_q != 4'h0) begin
            wtr_q <= wtr_q - 4'h1;
        end
    end

    // Command issue and spacing
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q <= CTL_IDLE;
            cs_n_q <= 1'b1;
            ca_rise_q <= '0;
            ca_fall_q <= '0;
            gap_q <= 32'h0000_0000;
            refused_q <= 1'b0;
        end else begin
            cs_n_q <= 1'b1;
            refused_q <= 1'b0;
            case (state_q)
                CTL_IDLE: begin
                    if (take && illegal) begin
                        refused_q <= 1'b1;
                    end else if (take && i_req_write) begin
                        cs_n_q <= 1'b0;
                        ca_rise_q <= {i_req_addr[5:0],
                            CMD_WRITE_CODE}; // RL13 RL14
                        ca_fall_q <= {i_req_wdata, i_req_addr[7:6]};
                        if (i_req_addr == RESET_REG_ADDR) begin
                            state_q <= CTL_INIT;
                            gap_q <= 32'(INIT_WAIT); // RL21
                        end else begin
                            state_q <= CTL_GAP;
                            gap_q <= 32'(WRITE_CMD_PERIOD - 1); // RL15
                        end
                    end else if (take) begin
                        cs_n_q <= 1'b0;
                        ca_rise_q <= {i_req_addr[5:0],
                            CMD_READ_CODE}; // RL22
                        ca_fall_q <= {8'h00, i_req_addr[7:6]};
                        state_q <= CTL_READ; // RL2 RL12
                    end
                end
                CTL_GAP, CTL_INIT: begin
                    if (gap_q == 32'h0000_0000) begin
                        state_q <= CTL_IDLE;
                    end else begin
                        gap_q <= gap_q - 32'h0000_0001;
                    end
                end
                CTL_READ: begin
                    if (link.dq_oe
                            && beat_q == 2'(BURST_BEATS - 1)) begin
                        state_q <= CTL_IDLE;
                    end
                end
                default: begin
                    state_q <= CTL_IDLE;
                end
            endcase
        end
    end

    // Read burst collection
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            beat_q <= 2'd0;
            rd_data_q <= '0;
            pat_q <= 4'h0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            if (state_q == CTL_READ && link.dq_oe) begin
                beat_q <= beat_q + 2'd1;
                pat_q[beat_q] <= link.dq[0]; // RL8
                if (beat_q == 2'd0) begin
                    rd_data_q <= link.dq[MD_W-1:0]; // RL23
                end
                if (beat_q == 2'(BURST_BEATS - 1)) begin
                    rd_valid_q <= 1'b1;
                end
            end else if (state_q != CTL_READ) begin
                beat_q <= 2'd0;
            end
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.ca_rise = ca_rise_q;
    assign link.ca_fall = ca_fall_q;
    assign o_req_refused = refused_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_data = rd_data_q;
    assign o_rd_pattern = pat_q;
    assign o_busy = (state_q != CTL_IDLE);

endmodule

// ### bench/mra_link_props.sv
/*
 * Checker for the mode-register link between controller and device.
 * Assumes it sees the link signals as plain inputs and the bench reset.
 */
`timescale 1ns/1ps
module mra_link_props
    import mra_pkg::*;
#(
    parameter int DQ_W = 16
) (
    input wire logic clk,
    input wire logic i_rst,
    input wire logic cs_n,
    input wire logic [CA_W-1:0] ca_rise,
    input wire logic [CA_W-1:0] ca_fall,
    input wire logic [DQ_W-1:0] dq,
    input wire logic dq_oe
);
    logic rd_cmd;
    logic wr_cmd;
    logic [7:0] cmd_addr;
    logic [DQ_W-1:0] ones;

    assign ones = {DQ_W{1'b1}};
    assign cmd_addr = {ca_fall[1:0], ca_rise[9:4]};
    assign rd_cmd = !cs_n && ca_rise[3:0] == CMD_READ_CODE;
    assign wr_cmd = !cs_n && ca_rise[3:0] == CMD_WRITE_CODE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (i_rst);

    a_read_burst_len: assert property (
        rd_cmd |-> ##4 dq_oe [*4] ##1 !dq_oe)
        else $error("read burst not four beats after latency");
    a_oe_has_cause: assert property (
        $rose(dq_oe) |-> $past(rd_cmd, 4))
        else $error("data driven without a read command");
    a_read_nop_gap: assert property (
        rd_cmd |=> cs_n [*7])
        else $error("command issued during read period");
    a_write_nop_gap: assert property (
        wr_cmd |=> cs_n [*5])
        else $error("command issued during write period");
    a_write_no_data: assert property (
        wr_cmd |=> !dq_oe [*5])
        else $error("write command produced read data");
    a_cal_a_beats: assert property (
        rd_cmd && cmd_addr == CAL_A_ADDR |->
            ##4 dq == ones ##1 dq == '0 ##1 dq == ones ##1 dq == '0)
        else $error("pattern A beats wrong");
    a_cal_b_beats: assert property (
        rd_cmd && cmd_addr == CAL_B_ADDR |->
            ##4 dq == '0 ##1 dq == '0 ##1 dq == ones ##1 dq == ones)
        else $error("pattern B beats wrong");
    a_plain_read_lanes: assert property (
        rd_cmd && cmd_addr != CAL_A_ADDR && cmd_addr != CAL_B_ADDR |->
            ##4 dq[DQ_W-1:8] == '0 ##1 (dq == '0) [*3])
        else $error("ordinary read lanes beyond byte not quiet");
    a_reset_nop_gap: assert property (
        wr_cmd && cmd_addr == RESET_REG_ADDR |=> cs_n [*8])
        else $error("command issued during initialisation");
endmodule

// ### bench/mode_register_access_tb.sv
/*
 * Testbench joining controller and device over the link interface.
 * Assumes shortened sensor interval (50) and init wait (10).
 */
`timescale 1ns/1ps
module mode_register_access_tb;
    import mra_pkg::*;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected at %0t: got %0h expected %0h", \
    $time, g, e); end end

    logic clk = 0;
    logic i_rst = 1;
    logic bank = 0, lp_exit = 0, burst_write = 0;
    logic req_valid = 0, req_write = 0;
    logic [2:0] temp_code = 3'h0;
    logic [7:0] req_addr = 8'h00, req_wdata = 8'h00;
    logic initialising, over_85, req_ready, req_refused, rd_valid, busy;
    logic [2:0] temp_status;
    logic [7:0] rd_data;
    logic [3:0] rd_pattern;
    logic refused;
    int n_mismatch = 0, checks_done = 0, init_cycles = 0, busy_cycles = 0;

    always #5 clk = ~clk;
    always @(negedge clk) begin
        if (initialising === 1'b1) init_cycles++;
        if (busy === 1'b1) busy_cycles++;
    end

    mra_link_if link (.clk(clk));
    mra_device #(.SENSOR_CYCLES(50), .INIT_WAIT(10)) u_mra_device (
        .i_core_clk(clk), .i_rst(i_rst), .link(link), .i_bank_active(bank),
        .i_temp_code(temp_code), .i_lp_exit(lp_exit),
        .o_initialising(initialising), .o_temp_status(temp_status),
        .o_temp_over_85(over_85));
    mra_controller #(.INIT_WAIT(10)) u_mra_controller (
        .i_core_clk(clk), .i_rst(i_rst), .link(link),
        .i_req_valid(req_valid), .i_req_write(req_write),
        .i_req_addr(req_addr), .i_req_wdata(req_wdata),
        .i_bank_active(bank), .i_burst_write(burst_write),
        .o_req_ready(req_ready), .o_req_refused(req_refused),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_rd_pattern(rd_pattern), .o_busy(busy));
    mra_link_props u_mra_link_props (
        .clk(clk), .i_rst(i_rst), .cs_n(link.cs_n), .ca_rise(link.ca_rise),
        .ca_fall(link.ca_fall), .dq(link.dq), .dq_oe(link.dq_oe));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        n_mismatch++;
        $display("unexpected at %0t: wait limit reached", $time);
        report_and_stop();
    endtask

    // One request, held until taken, then waits for its completion
    task automatic req(input logic w, input logic [7:0] a,
            input logic [7:0] d);
        int k;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_valid = 1;
        for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge clk);
        if (req_ready !== 1'b1) timed_out();
        @(negedge clk);
        req_valid = 0;
        refused = req_refused;
        if (!w && refused !== 1'b1) begin
            for (k = 0; k < 20 && rd_valid !== 1'b1; k++) @(negedge clk);
            if (rd_valid !== 1'b1) timed_out();
        end
        // Valid stays low for at least one edge between requests
        @(negedge clk);
        for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge clk);
        if (req_ready !== 1'b1) timed_out();
    endtask

    task automatic t_write_read();
        req(1, 8'h10, 8'hA5);
        req(0, 8'h10, 8'h00);
        `CHK(rd_data, 8'hA5)
        req(1, 8'h55, 8'h3C);
        req(0, 8'h15, 8'h00);
        `CHK(rd_data, REG_RESET_VALUE)
        req(1, DEVICE_INFO_ADDR, 8'h3C);
        req(0, DEVICE_INFO_ADDR, 8'h00);
        `CHK(rd_data, REG_RESET_VALUE)
        req(1, CAL_A_ADDR, 8'hFF);
        req(0, CAL_A_ADDR, 8'h00);
        `CHK(rd_pattern, 4'h5)
        req(0, CAL_B_ADDR, 8'h00);
        `CHK(rd_pattern, 4'hC)
        $display("test write_read done");
    endtask

    task automatic t_bank_active();
        bank = 1;
        req(1, 8'h11, 8'h5A);
        `CHK(refused, 1'b1)
        req(0, CAL_A_ADDR, 8'h00);
        `CHK(refused, 1'b1)
        req(0, 8'h10, 8'h00);
        `CHK(refused, 1'b0)
        `CHK(rd_data, 8'hA5)
        bank = 0;
        req(0, 8'h11, 8'h00);
        `CHK(rd_data, REG_RESET_VALUE)
        $display("test bank_active done");
    endtask

    task automatic t_burst_gap();
        int k;
        req_write = 0;
        burst_write = 1;
        @(negedge clk);
        burst_write = 0;
        `CHK(req_ready, 1'b0)
        for (k = 0; k < 10 && req_ready !== 1'b1; k++) @(negedge clk);
        `CHK(k, WR_TO_READ_GAP - 1)
        req(0, 8'h10, 8'h00);
        `CHK(rd_data, 8'hA5)
        $display("test burst_gap done");
    endtask

    task automatic t_temperature();
        int k;
        temp_code = TEMP_HOT_CODE;
        for (k = 0; k < 52 && temp_status !== TEMP_HOT_CODE; k++) begin
            @(negedge clk);
        end
        `CHK(temp_status, TEMP_HOT_CODE)
        `CHK(over_85, 1'b1)
        req(0, TEMP_STATUS_ADDR, 8'h00);
        `CHK(rd_data[2:0], 3'h3)
        temp_code = 3'h5;
        lp_exit = 1;
        @(negedge clk);
        lp_exit = 0;
        `CHK(temp_status, 3'h5)
        `CHK(over_85, 1'b0)
        $display("test temperature done");
    endtask

    task automatic t_reset_write();
        req(1, 8'h12, 8'h77);
        init_cycles = 0;
        busy_cycles = 0;
        req(1, RESET_REG_ADDR, 8'hFF);
        `CHK(init_cycles, 10)
        `CHK(busy_cycles, 11)
        req(0, 8'h12, 8'h00);
        `CHK(rd_data, REG_RESET_VALUE)
        req(0, 8'h10, 8'h00);
        `CHK(rd_data, REG_RESET_VALUE)
        $display("test reset_write done");
    endtask

    initial begin
        repeat (2) @(negedge clk);
        i_rst = 0;
        t_write_read();
        t_bank_active();
        t_burst_gap();
        t_temperature();
        t_reset_write();
        report_and_stop();
    end
endmodule
